// ===== design/mmb_pkg.sv
`default_nettype none
package mmb_pkg;
	// ----------------------------------------
	// encodings
	// ----------------------------------------
	localparam logic [7:0]  OPC_BANK_LOAD  = 8'h01;
	localparam logic [3:0]  PFX_MOVE_SRC   = 4'hC;
	localparam logic [3:0]  PFX_MOVE_DST   = 4'hF;
	localparam int          WORD_W         = 16;
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] ADDR_RESET     = 12'h000;
	localparam logic [7:0]  BANK_RESET     = 8'h00;
	localparam logic [3:0]  BANK_HI_ZERO   = 4'h0;
	localparam int          PHASES         = 4;
	// ----------------------------------------
	// field positions in the instruction word
	// ----------------------------------------
	localparam int          OPC_MSB        = 15;
	localparam int          OPC_LSB        = 8;
	localparam int          PFX_LSB        = 12;
	localparam int          FIELD_MSB      = 11;
	localparam int          FIELD_LSB      = 0;
	localparam int          LIT_MSB        = 7;
	localparam int          LIT_LSB        = 0;
	localparam int          NIB_MSB        = 3;
	localparam int          BANK_HI_LSB    = 4;
	// ----------------------------------------
	// quarter phases, one-hot
	// ----------------------------------------
	typedef enum logic [3:0] {
		Q1 = 4'b0001,
		Q2 = 4'b0010,
		Q3 = 4'b0100,
		Q4 = 4'b1000
	} mmb_phase_t;
	// ----------------------------------------
	// execution states, one-hot
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_SINGLE = 3'b001,
		ST_MOVE2  = 3'b010,
		ST_OTHER  = 3'b100
	} mmb_state_t;
endpackage
`default_nettype wire

// ===== design/mmb_phase_gen.sv
`default_nettype none
module mmb_phase_gen (
	input  wire logic              CLK,
	input  wire logic              NRST,
	output var  mmb_pkg::mmb_phase_t PHASE
);
	// ----------------------------------------
	// rotating quarter-phase ring
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			PHASE <= mmb_pkg::Q1;
		end else begin
			case (PHASE)
				mmb_pkg::Q1: PHASE <= mmb_pkg::Q2;
				mmb_pkg::Q2: PHASE <= mmb_pkg::Q3;
				mmb_pkg::Q3: PHASE <= mmb_pkg::Q4;
				mmb_pkg::Q4: PHASE <= mmb_pkg::Q1;
				default:     PHASE <= mmb_pkg::Q1;
			endcase
		end
	end

	chk_ring_order: assert property (@(posedge CLK) disable iff (!NRST)
		PHASE == mmb_pkg::Q1 |=> PHASE == mmb_pkg::Q2 ##1 PHASE == mmb_pkg::Q3
		##1 PHASE == mmb_pkg::Q4) else $error("phase ring out of order");
endmodule
`default_nettype wire

// ===== design/mmb_exec.sv
`default_nettype none
// How it works
// - bank register takes literal low nibble; upper nibble always zero.
// - bank load: decode, read literal, process, write bank register in Q4.
// - move is two words: 0xC plus source, then 0xF plus destination.
// - both move addresses span 0..4095 directly, ignoring the bank register.
// - move cycle one: decode, read source in Q2, Q4 does nothing.
// - move cycle two: no read at all, write held data at Q4.
// - move copies data unchanged, flags untouched; accumulator may be either end.
module mmb_exec (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic [15:0] INSTR,
	input  wire logic [7:0]  RD_DATA,
	output var  logic        RD_EN,
	output var  logic [11:0] RD_ADDR,
	output var  logic        WR_EN,
	output var  logic [11:0] WR_ADDR,
	output var  logic [7:0]  WR_DATA,
	output var  logic [7:0]  BANK_SELECT,
	output var  logic        FLAGS_WE,
	output var  logic        CYCLE_END
);
	// ----------------------------------------
	// phases and decode
	// ----------------------------------------
	mmb_pkg::mmb_phase_t phase;
	mmb_pkg::mmb_state_t state;
	logic [7:0]          literal;
	logic [7:0]          held;
	logic [11:0]         src;
	logic [7:0]          opcode;
	logic [3:0]          prefix;
	logic [11:0]         field;
	logic [3:0]          nibble;
	logic                is_bank;
	logic                is_move;
	logic                is_dest;
	logic                in_q1;
	logic                in_q2;
	logic                in_q3;
	logic                in_q4;
	logic                first_cycle;
	logic                second_cycle;
	logic                capture_go;
	logic                bank_go;
	logic                write_go;

	// ----------------------------------------
	// elaboration checks on the word layout and the phase ring width
	// ----------------------------------------
	if (mmb_pkg::PFX_LSB != mmb_pkg::ADDR_W) begin : g_bad_field
		$error("address field must sit right below the prefix");
	end
	if (mmb_pkg::OPC_MSB != mmb_pkg::WORD_W - 1) begin : g_bad_word
		$error("opcode must sit at the top of the word");
	end
	if ($bits(mmb_pkg::mmb_phase_t) != mmb_pkg::PHASES) begin : g_bad_ring
		$error("phase ring must hold one bit per phase");
	end

	mmb_phase_gen u_phase (
		.CLK   (CLK),
		.NRST  (NRST),
		.PHASE (phase)
	);

	// ----------------------------------------
	// instruction fields
	// ----------------------------------------
	assign opcode  = INSTR[mmb_pkg::OPC_MSB:mmb_pkg::OPC_LSB];
	assign prefix  = INSTR[mmb_pkg::OPC_MSB:mmb_pkg::PFX_LSB];
	assign field   = INSTR[mmb_pkg::FIELD_MSB:mmb_pkg::FIELD_LSB];
	assign nibble  = literal[mmb_pkg::NIB_MSB:mmb_pkg::LIT_LSB];
	assign is_bank = (opcode == mmb_pkg::OPC_BANK_LOAD);
	assign is_move = (prefix == mmb_pkg::PFX_MOVE_SRC);
	assign is_dest = (prefix == mmb_pkg::PFX_MOVE_DST);

	// ----------------------------------------
	// phase and cycle strobes
	// ----------------------------------------
	assign in_q1        = (phase == mmb_pkg::Q1);
	assign in_q2        = (phase == mmb_pkg::Q2);
	assign in_q3        = (phase == mmb_pkg::Q3);
	assign in_q4        = (phase == mmb_pkg::Q4);
	assign first_cycle  = (state == mmb_pkg::ST_SINGLE);
	assign second_cycle = (state == mmb_pkg::ST_MOVE2);
	assign capture_go   = in_q1 && first_cycle;
	assign bank_go      = in_q3 && first_cycle && is_bank;
	assign write_go     = in_q3 && second_cycle;
	assign CYCLE_END    = in_q4;
	assign FLAGS_WE     = 1'b0;

	// ----------------------------------------
	// cycle state: a second word consumed only after a move first word
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state <= mmb_pkg::ST_SINGLE;
		end else if (in_q4) begin
			case (state)
				mmb_pkg::ST_SINGLE: state <= is_move ? mmb_pkg::ST_MOVE2 : mmb_pkg::ST_SINGLE;
				mmb_pkg::ST_MOVE2:  state <= mmb_pkg::ST_SINGLE;
				default:            state <= mmb_pkg::ST_SINGLE;
			endcase
		end
	end

	// ----------------------------------------
	// operand capture
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			literal <= mmb_pkg::BANK_RESET;
			src     <= mmb_pkg::ADDR_RESET;
		end else if (capture_go) begin
			literal <= INSTR[mmb_pkg::LIT_MSB:mmb_pkg::LIT_LSB];
			src     <= field;
		end
	end

	// ----------------------------------------
	// source read in Q2 of move cycle one
	// ----------------------------------------
	always_comb begin
		RD_EN   = in_q2 && first_cycle && is_move;
		RD_ADDR = src;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			held <= mmb_pkg::BANK_RESET;
		end else if (RD_EN) begin
			held <= RD_DATA;
		end
	end

	// ----------------------------------------
	// destination write in Q4 of move cycle two
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			WR_EN   <= 1'b0;
			WR_ADDR <= mmb_pkg::ADDR_RESET;
			WR_DATA <= mmb_pkg::BANK_RESET;
		end else begin
			WR_EN <= write_go && is_dest;
			if (write_go) begin
				WR_ADDR <= field;
				WR_DATA <= held;
			end
		end
	end

	// ----------------------------------------
	// bank select register, written in Q4
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			BANK_SELECT <= mmb_pkg::BANK_RESET;
		end else if (bank_go) begin
			BANK_SELECT <= {mmb_pkg::BANK_HI_ZERO, nibble};
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_bank_hi_zero: assert property (@(posedge CLK) disable iff (!NRST)
		BANK_SELECT[mmb_pkg::LIT_MSB:mmb_pkg::BANK_HI_LSB] == mmb_pkg::BANK_HI_ZERO)
		else $error("bank upper nibble set");
	chk_bank_in_q4: assert property (@(posedge CLK) disable iff (!NRST)
		$changed(BANK_SELECT) |-> in_q4) else $error("bank written off Q4");
	chk_bank_value: assert property (@(posedge CLK) disable iff (!NRST)
		bank_go |=> BANK_SELECT == {mmb_pkg::BANK_HI_ZERO, $past(nibble)})
		else $error("bank literal wrong");
	chk_bank_kept: assert property (@(posedge CLK) disable iff (!NRST)
		!bank_go |=> $stable(BANK_SELECT)) else $error("bank changed without load");
	chk_literal_take: assert property (@(posedge CLK) disable iff (!NRST)
		capture_go |=> literal == $past(INSTR[mmb_pkg::LIT_MSB:mmb_pkg::LIT_LSB]))
		else $error("literal not taken");
	chk_move_decode: assert property (@(posedge CLK) disable iff (!NRST)
		RD_EN |-> is_move) else $error("read without move");
	chk_move_pairs: assert property (@(posedge CLK) disable iff (!NRST)
		in_q4 && first_cycle && is_move |=> second_cycle) else $error("second word lost");
	chk_state_legal: assert property (@(posedge CLK) disable iff (!NRST)
		$onehot(state) && state != mmb_pkg::ST_OTHER) else $error("illegal cycle state");
	chk_read_q2: assert property (@(posedge CLK) disable iff (!NRST)
		RD_EN |-> in_q2 && first_cycle) else $error("read phase");
	chk_read_addr: assert property (@(posedge CLK) disable iff (!NRST)
		RD_EN |-> RD_ADDR == field) else $error("read address");
	chk_read_pulse: assert property (@(posedge CLK) disable iff (!NRST)
		RD_EN |=> !RD_EN) else $error("read longer than one clock");
	chk_no_read_c2: assert property (@(posedge CLK) disable iff (!NRST)
		second_cycle |-> !RD_EN) else $error("read in move cycle two");
	chk_write_q4: assert property (@(posedge CLK) disable iff (!NRST)
		WR_EN |-> in_q4 && second_cycle) else $error("write phase");
	chk_write_addr: assert property (@(posedge CLK) disable iff (!NRST)
		WR_EN |-> WR_ADDR == field) else $error("write address");
	chk_write_pulse: assert property (@(posedge CLK) disable iff (!NRST)
		WR_EN |=> !WR_EN) else $error("write longer than one clock");
	chk_move_data: assert property (@(posedge CLK) disable iff (!NRST)
		RD_EN ##1 1'b1 [*5] ##1 WR_EN |-> WR_DATA == $past(RD_DATA, 6))
		else $error("copy mismatch");
	chk_flags_kept: assert property (@(posedge CLK) disable iff (!NRST)
		!FLAGS_WE) else $error("flags written");
	chk_lone_nop: assert property (@(posedge CLK) disable iff (!NRST)
		first_cycle |-> !WR_EN) else $error("lone word wrote");
	chk_lone_dest: assert property (@(posedge CLK) disable iff (!NRST)
		in_q3 && first_cycle && is_dest |=> !WR_EN) else $error("lone destination wrote");

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	cov_bank: cover property (@(posedge CLK) disable iff (!NRST) $changed(BANK_SELECT));
	cov_bank_high: cover property (@(posedge CLK) disable iff (!NRST)
		bank_go && literal[mmb_pkg::LIT_MSB:mmb_pkg::BANK_HI_LSB] != mmb_pkg::BANK_HI_ZERO);
	cov_move: cover property (@(posedge CLK) disable iff (!NRST) WR_EN);
	cov_pair: cover property (@(posedge CLK) disable iff (!NRST)
		RD_EN ##6 WR_EN);
	cov_lone: cover property (@(posedge CLK) disable iff (!NRST)
		capture_go && is_dest);
endmodule
`default_nettype wire

// ===== verif/mmb_dmem.sv
`default_nettype none
module mmb_dmem (
	input  wire logic        CLK,
	input  wire logic        RD_EN,
	input  wire logic [11:0] RD_ADDR,
	input  wire logic        WR_EN,
	input  wire logic [11:0] WR_ADDR,
	input  wire logic [7:0]  WR_DATA,
	output var  logic [7:0]  RD_DATA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4096];
	logic [7:0] last = 8'h00;
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5A;
	end
	// unselected bus shows a non-value
	assign RD_DATA = RD_EN ? mem[RD_ADDR] : ~last;
	always @(posedge CLK) begin
		if (RD_EN) last <= mem[RD_ADDR];
		if (WR_EN) mem[WR_ADDR] <= WR_DATA;
	end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK, NRST, RD_EN, WR_EN, FLAGS_WE, CYCLE_END;
	logic [15:0] INSTR;
	logic [7:0]  RD_DATA, WR_DATA, BANK_SELECT, bank_exp;
	logic [11:0] RD_ADDR, WR_ADDR;
	logic [7:0]  shadow [4096];
	logic [11:0] rd_q [$];
	logic [19:0] wr_q [$];
	int          mismatches, total_checks, seed;
	mmb_exec dut_u (.CLK(CLK), .NRST(NRST), .INSTR(INSTR), .RD_DATA(RD_DATA),
		.RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR),
		.WR_DATA(WR_DATA), .BANK_SELECT(BANK_SELECT), .FLAGS_WE(FLAGS_WE),
		.CYCLE_END(CYCLE_END));
	mmb_dmem mem_u (.CLK(CLK), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .WR_EN(WR_EN),
		.WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one instruction cycle, returns at the falling edge inside Q1 of the next cycle
	task automatic issue(input logic [15:0] word);
		int waits;
		waits = 0;
		INSTR = word;
		do begin
			@(negedge CLK);
			waits++;
		end while (CYCLE_END !== 1'b1);
		chk(20'(waits), 20'(mmb_pkg::PHASES - 1));
		@(negedge CLK);
	endtask
	task automatic bank(input logic [7:0] k);
		issue({mmb_pkg::OPC_BANK_LOAD, k});
		bank_exp = {mmb_pkg::BANK_HI_ZERO, k[3:0]};
		issue(16'h0000);
		chk({12'h0, BANK_SELECT}, {12'h0, bank_exp});
	endtask
	task automatic move(input logic [11:0] src, input logic [11:0] dst);
		rd_q.push_back(src);
		wr_q.push_back({dst, shadow[src]});
		shadow[dst] = shadow[src];
		issue({mmb_pkg::PFX_MOVE_SRC, src});
		issue({mmb_pkg::PFX_MOVE_DST, dst});
		chk({12'h0, BANK_SELECT}, {12'h0, bank_exp});
	endtask
	always @(negedge CLK) begin
		if (NRST) chk({19'h0, FLAGS_WE}, 20'h0);
		if (NRST && RD_EN) begin
			if (rd_q.size() == 0) chk(20'hFFFFF, 20'h0);
			else chk({8'h00, RD_ADDR}, {8'h00, rd_q.pop_front()});
		end
		if (NRST && WR_EN) begin
			if (wr_q.size() == 0) chk(20'hFFFFF, 20'h0);
			else chk({WR_ADDR, WR_DATA}, wr_q.pop_front());
		end
	end
	initial begin
		#50us;
		mismatches++;
		test_done;
	end
	initial begin
		logic [11:0] src, dst;
		seed = 14986;
		mismatches = 0;
		total_checks = 0;
		NRST = 1'b0;
		INSTR = 16'h0000;
		bank_exp = mmb_pkg::BANK_RESET;
		for (int i = 0; i < 4096; i++) shadow[i] = i[7:0] ^ 8'h5A;
		repeat (10) @(negedge CLK);
		chk({12'h0, BANK_SELECT}, {12'h0, mmb_pkg::BANK_RESET});
		NRST = 1'b1;
		bank(8'hF5);
		for (int n = 0; n < 12; n++) begin
			bank(8'($random(seed)));
			src = (n == 0) ? 12'hFFF : 12'($random(seed));
			// stack top and program counter bytes never targeted
			dst = (n == 1) ? 12'h000 : 12'($unsigned($random(seed)) % 3968);
			move(src, dst);
			if (n % 4 == 3) issue({mmb_pkg::PFX_MOVE_DST, dst});
		end
		issue(16'h0000);
		chk(20'(rd_q.size() + wr_q.size()), 20'h0);
		test_done;
	end
endmodule
`default_nettype wire
